// [design/tal_defs.vh]
// Constants of the threshold and AND/OR logic engine
`ifndef TAL_DEFS_VH
`define TAL_DEFS_VH
// Sizes
`define TAL_N_AI 4
`define TAL_N_DI 8
`define TAL_N_DO 8
`define TAL_N_VDI 8
`define TAL_N_AL 16
`define TAL_N_ST 16
`define TAL_N_LIST 16
`define TAL_MAX_COND 30
`define TAL_SEL_W 6
`define TAL_CNT_W 5
`define TAL_MEAS_W 16
`define TAL_DLY_W 16
// Condition pool layout (bit positions)
`define TAL_POOL_DI 0
`define TAL_POOL_VDI 8
`define TAL_POOL_DO 16
`define TAL_POOL_AL 24
`define TAL_POOL_ST 40
`define TAL_POOL_AT 56
`define TAL_POOL_W 64
// Comparator configuration field positions
`define TAL_CFG_BELOW 0
`define TAL_CFG_SETS 1
// Timing: delay unit and clock period in ns
`define TAL_DLY_UNIT_NS 100000000
`define TAL_CLK_NS 100
`define TAL_BASE_CYCLES (`TAL_DLY_UNIT_NS / `TAL_CLK_NS)
// Reset values
`define TAL_FLAG_RST 1'b0
`endif

// [design/tal_thresh.v]
// Pair of delayed threshold comparators driving one analogue status flag
`include "tal_defs.vh"
`default_nettype none
module tal_thresh
(
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Delay time base, one pulse per delay unit
   input wire base_tick,
   // Measurement and comparator settings
   input wire [`TAL_MEAS_W-1:0] meas,
   input wire [2*`TAL_MEAS_W-1:0] thr,
   input wire [2*`TAL_DLY_W-1:0] dly,
   input wire [3:0] cfg,
   // Status flag
   output reg flag_reg
);
   wire [1:0] qual;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_cmp
         wire [`TAL_MEAS_W-1:0] t = thr[g*`TAL_MEAS_W +: `TAL_MEAS_W];
         wire [`TAL_DLY_W-1:0] d = dly[g*`TAL_DLY_W +: `TAL_DLY_W];
         wire below = cfg[2*g+`TAL_CFG_BELOW];
         wire cond = below ? (meas < t) : (meas > t);
         reg [`TAL_DLY_W-1:0] cnt_reg;
         reg [`TAL_DLY_W-1:0] cnt_next;
         always @*
         begin
            cnt_next = cnt_reg;
            if (!cond)
               cnt_next = {`TAL_DLY_W{1'b0}};
            else if (base_tick && cnt_reg < d)
               cnt_next = cnt_reg + 16'h0001;
         end
         always @(posedge clk)
         begin
            if (!rst_n)
               cnt_reg <= {`TAL_DLY_W{1'b0}};
            else
               cnt_reg <= cnt_next;
         end
         assign qual[g] = cond && (cnt_reg >= d);
      end
   endgenerate

   wire set_req = (qual[0] & cfg[`TAL_CFG_SETS]) | (qual[1] & cfg[2+`TAL_CFG_SETS]);
   wire clr_req = (qual[0] & ~cfg[`TAL_CFG_SETS]) | (qual[1] & ~cfg[2+`TAL_CFG_SETS]);

   always @(posedge clk)
   begin
      if (!rst_n)
         flag_reg <= `TAL_FLAG_RST;
      else if (set_req)
         flag_reg <= 1'b1;
      else if (clr_req)
         flag_reg <= 1'b0;
      else
         flag_reg <= flag_reg;
   end
endmodule // tal_thresh
`default_nettype wire

// [design/tal_logic.v]
// Threshold comparators and AND/OR condition combiners
//
// Functional notes
// - Two independent comparators per physical or virtual analogue input, none for shared.
// - Config bit 0 clear means above threshold, set means below threshold.
// - Config bit 1 set: qualified condition sets the input status flag.
// - Config bit 1 clear: qualified condition clears the flag, giving hysteresis.
// - A condition acts only after holding for the comparator's delay.
// - A list of conditions yields one result for an output or virtual input.
// - Outputs follow the result only with the combiner function selected.
// - Each list is all-AND or all-OR, never mixed.
// - Up to 30 conditions per list, each with its own invert.
// - Conditions: inputs, outputs, anomalies, internal statuses, threshold flags.
// - Input and output conditions use logical state, polarity applied.
// - Warn when a virtual input is driven by both PLC and a list.
// - Combiner-driven outputs and virtual inputs serve as conditions elsewhere.
`include "tal_defs.vh"
`default_nettype none
module tal_logic
#(
   parameter BASE_CYCLES = `TAL_BASE_CYCLES
)
(
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Controller scan tick
   input wire scan_tick,
   // Analogue inputs and their two comparators each
   input wire [`TAL_N_AI*`TAL_MEAS_W-1:0] ai_meas,
   input wire [`TAL_N_AI*2*`TAL_MEAS_W-1:0] ai_thr,
   input wire [`TAL_N_AI*2*`TAL_DLY_W-1:0] ai_dly,
   input wire [`TAL_N_AI*4-1:0] ai_cfg,
   // Digital inputs
   input wire [`TAL_N_DI-1:0] di_pin,
   input wire [`TAL_N_DI-1:0] di_polarity,
   // Digital outputs
   input wire [`TAL_N_DO-1:0] output_func_combiner,
   input wire [`TAL_N_DO-1:0] do_other_state,
   input wire [`TAL_N_DO-1:0] do_polarity,
   // Virtual digital inputs
   input wire [`TAL_N_VDI-1:0] vdi_plc_en,
   input wire [`TAL_N_VDI-1:0] vdi_plc_val,
   // Anomalies and internal statuses
   input wire [`TAL_N_AL-1:0] anomaly_present,
   input wire [`TAL_N_ST-1:0] internal_status,
   // Lists: 0..7 feed outputs, 8..15 feed virtual inputs
   input wire [`TAL_N_LIST-1:0] lst_en,
   input wire [`TAL_N_LIST-1:0] lst_or,
   input wire [`TAL_N_LIST*`TAL_CNT_W-1:0] lst_cnt,
   input wire [`TAL_N_LIST*`TAL_MAX_COND*`TAL_SEL_W-1:0] lst_sel,
   input wire [`TAL_N_LIST*`TAL_MAX_COND-1:0] lst_inv,
   // Results
   output reg [`TAL_N_DI-1:0] input_logic_state,
   output reg [`TAL_N_DO-1:0] output_logic_state,
   output reg [`TAL_N_DO-1:0] do_pin,
   output reg [`TAL_N_VDI-1:0] vdi_state,
   output reg [`TAL_N_AI-1:0] analog_threshold_flag,
   output reg [`TAL_N_LIST-1:0] lst_result,
   output reg dual_driver_warning
);
   // Evaluates one list over the condition pool
   function eval_list;
      input [`TAL_MAX_COND*`TAL_SEL_W-1:0] sel;
      input [`TAL_MAX_COND-1:0] inv;
      input [`TAL_CNT_W-1:0] cnt;
      input is_or;
      input [`TAL_POOL_W-1:0] pool;
      integer k;
      reg acc;
      reg c;
      begin
         acc = ~is_or;
         for (k = 0; k < `TAL_MAX_COND; k = k + 1)
         begin
            if (k < cnt)
            begin
               c = pool[sel[k*`TAL_SEL_W +: `TAL_SEL_W]] ^ inv[k];
               acc = is_or ? (acc | c) : (acc & c);
            end
         end
         // Empty list is false
         eval_list = (cnt != 5'h00) & acc;
      end
   endfunction

   // Delay time base
   reg [19:0] pre_reg;
   reg base_tick_reg;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         pre_reg <= 20'h00000;
         base_tick_reg <= 1'b0;
      end
      else if (pre_reg >= BASE_CYCLES - 1)
      begin
         pre_reg <= 20'h00000;
         base_tick_reg <= 1'b1;
      end
      else
      begin
         pre_reg <= pre_reg + 20'h00001;
         base_tick_reg <= 1'b0;
      end
   end

   // Comparator pairs, one per analogue input
   wire [`TAL_N_AI-1:0] flag_w;
   genvar a;
   generate
      for (a = 0; a < `TAL_N_AI; a = a + 1)
      begin : g_ai
         tal_thresh u_thresh
         (
            .clk(clk),
            .rst_n(rst_n),
            .base_tick(base_tick_reg),
            .meas(ai_meas[a*`TAL_MEAS_W +: `TAL_MEAS_W]),
            .thr(ai_thr[a*2*`TAL_MEAS_W +: 2*`TAL_MEAS_W]),
            .dly(ai_dly[a*2*`TAL_DLY_W +: 2*`TAL_DLY_W]),
            .cfg(ai_cfg[a*4 +: 4]),
            .flag_reg(flag_w[a])
         );
      end
   endgenerate

   always @(posedge clk)
   begin
      if (!rst_n)
         analog_threshold_flag <= {`TAL_N_AI{1'b0}};
      else
         analog_threshold_flag <= flag_w;
   end

   // Condition pool from registered states plus the anomaly_present and internal_status inputs as they arrive
   wire [`TAL_POOL_W-1:0] pool = {4'h0, analog_threshold_flag, internal_status, anomaly_present,
      output_logic_state, vdi_state, input_logic_state};

   // List evaluation
   wire [`TAL_N_LIST-1:0] eval_w;
   genvar l;
   generate
      for (l = 0; l < `TAL_N_LIST; l = l + 1)
      begin : g_lst
         assign eval_w[l] = lst_en[l] & eval_list(lst_sel[l*`TAL_MAX_COND*`TAL_SEL_W +: `TAL_MAX_COND*`TAL_SEL_W],
            lst_inv[l*`TAL_MAX_COND +: `TAL_MAX_COND], lst_cnt[l*`TAL_CNT_W +: `TAL_CNT_W], lst_or[l], pool);
      end
   endgenerate

   wire [`TAL_N_LIST-1:0] lst_result_next = scan_tick ? eval_w : lst_result;
   wire [`TAL_N_DO-1:0] do_res_next = lst_result_next[`TAL_N_DO-1:0];
   wire [`TAL_N_VDI-1:0] vdi_res_next = lst_result_next[`TAL_N_LIST-1:`TAL_N_DO];
   wire [`TAL_N_DO-1:0] do_logic_next = (output_func_combiner & do_res_next) |
      (~output_func_combiner & do_other_state);
   wire [`TAL_N_VDI-1:0] vdi_lst_en = lst_en[`TAL_N_LIST-1:`TAL_N_DO];
   // PLC keeps the virtual input when both drive it
   wire [`TAL_N_VDI-1:0] vdi_next = (vdi_plc_en & vdi_plc_val) |
      (~vdi_plc_en & vdi_lst_en & vdi_res_next);

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         lst_result <= {`TAL_N_LIST{1'b0}};
         input_logic_state <= {`TAL_N_DI{1'b0}};
         output_logic_state <= {`TAL_N_DO{1'b0}};
         do_pin <= {`TAL_N_DO{1'b0}};
         vdi_state <= {`TAL_N_VDI{1'b0}};
         dual_driver_warning <= 1'b0;
      end
      else
      begin
         lst_result <= lst_result_next;
         input_logic_state <= di_pin ^ di_polarity;
         output_logic_state <= do_logic_next;
         do_pin <= do_logic_next ^ do_polarity;
         vdi_state <= vdi_next;
         dual_driver_warning <= |(vdi_plc_en & vdi_lst_en);
      end
   end
endmodule // tal_logic
`default_nettype wire

// [verification/tal_logic_checker.sv]
// Concurrent checks on the ports of the logic engine
`default_nettype none
module tal_logic_checker
(
   // Clock, reset, tick
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scan_tick,
   // Inputs
   input wire logic [7:0] di_pin,
   input wire logic [7:0] di_polarity,
   input wire logic [7:0] output_func_combiner,
   input wire logic [7:0] do_other_state,
   input wire logic [7:0] do_polarity,
   input wire logic [7:0] vdi_plc_en,
   input wire logic [7:0] vdi_plc_val,
   input wire logic [15:0] lst_en,
   // Outputs
   input wire logic [7:0] input_logic_state,
   input wire logic [7:0] output_logic_state,
   input wire logic [7:0] do_pin,
   input wire logic [7:0] vdi_state,
   input wire logic [3:0] analog_threshold_flag,
   input wire logic [15:0] lst_result,
   input wire logic dual_driver_warning
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ils_polarity: assert property ($past(rst_n) |-> input_logic_state == ($past(di_pin) ^ $past(di_polarity)))
      else $error("input state wrong");
   a_do_polarity: assert property ($past(rst_n) |-> do_pin == (output_logic_state ^ $past(do_polarity)))
      else $error("output pin wrong");
   a_out_other: assert property ($past(rst_n) |->
      ((output_logic_state ^ $past(do_other_state)) & ~$past(output_func_combiner)) == 8'h00)
      else $error("output not in combiner wrong");
   a_out_follows: assert property ($past(rst_n) |->
      ((output_logic_state ^ lst_result[7:0]) & $past(output_func_combiner)) == 8'h00)
      else $error("output not following list");
   a_vdi_plc: assert property ($past(rst_n) |-> ((vdi_state ^ $past(vdi_plc_val)) & $past(vdi_plc_en)) == 8'h00)
      else $error("virtual input not from plc");
   a_dual_warn: assert property ($past(rst_n) |->
      dual_driver_warning == |($past(vdi_plc_en) & $past(lst_en[15:8])))
      else $error("dual driver warning wrong");
   a_result_holds: assert property ($past(rst_n) && !$past(scan_tick) |-> $stable(lst_result))
      else $error("result moved without tick");
   a_list_off: assert property ($past(rst_n) && $past(scan_tick) |-> (lst_result & ~$past(lst_en)) == 16'h0000)
      else $error("disabled list true");
   cover property (scan_tick ##1 |lst_result);
   cover property ($rose(analog_threshold_flag[0]));
   cover property ($rose(dual_driver_warning));
endmodule // tal_logic_checker
bind tal_logic tal_logic_checker chk_u (.*);
`default_nettype wire

// [verification/tal_logic_tb_top.sv]
// Self-checking bench of the threshold and AND/OR logic engine
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tal_logic_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, scan_tick = 0, dual_driver_warning;
   logic [127:0] ai_thr = '0, ai_dly = '0;
   logic [63:0] ai_meas = '0, m, qm[$], qe[$];
   logic [79:0] lst_cnt = '0;
   logic [2879:0] lst_sel = '0;
   logic [479:0] lst_inv = '0;
   logic [15:0] lf = 16'h92C9, ai_cfg = '0, anomaly_present = '0, internal_status = '0, lst_en = '0, lst_or = '0;
   logic [15:0] lst_result;
   logic [7:0] di_pin = '0, di_polarity = '0, output_func_combiner = '0, do_other_state = '0, do_polarity = '0;
   logic [7:0] vdi_plc_en = '0, vdi_plc_val = '0, input_logic_state, output_logic_state, do_pin, vdi_state;
   logic [3:0] analog_threshold_flag;
   int failures = 0, checks = 0;
   tal_logic #(.BASE_CYCLES(4)) dut_u (.*);
   always #50 clk = ~clk;
   function automatic logic [15:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction
   task automatic note(logic [63:0] mk, logic [63:0] ex);
      qm.push_back(mk);
      qe.push_back(ex & mk);
   endtask
   always @(posedge clk)
   begin
      #10;
      if (qm.size() > 0)
      begin
         m = qm.pop_front();
         `CHK({11'h0, analog_threshold_flag, dual_driver_warning, vdi_state, do_pin, output_logic_state,
            input_logic_state, lst_result} & m, qe.pop_front())
      end
   end
   task automatic rand_scan();
      logic [15:0] s, r, res;
      logic [7:0] o;
      logic [63:0] pool;
      logic a, v;
      @(negedge clk);
      {di_pin, di_polarity} = rnd();
      {anomaly_present, internal_status, lst_en, lst_or} = {rnd(), rnd(), rnd(), rnd()};
      {output_func_combiner, do_other_state, do_polarity, vdi_plc_en, vdi_plc_val, s[7:0]} = {rnd(), rnd(), rnd()};
      pool = {8'h0, internal_status, anomaly_present, 16'h0, di_pin ^ di_polarity};
      for (int l = 0; l < 16; l++)
      begin
         s = rnd();
         lst_cnt[l*5+:5] = s[4:0];
         a = !lst_or[l];
         for (int k = 0; k < 30; k++)
         begin
            r = rnd();
            lst_sel[(l*30+k)*6+:6] = r[0] ? 6'h18 + r[5:1] : {3'h0, r[3:1]};
            lst_inv[l*30+k] = r[9];
            v = pool[lst_sel[(l*30+k)*6+:6]] ^ r[9];
            if (k < s[4:0])
               a = lst_or[l] ? a | v : a & v;
         end
         res[l] = lst_en[l] & (s[4:0] != 5'h0) & a;
      end
      o = output_func_combiner & res[7:0] | ~output_func_combiner & do_other_state;
      @(negedge clk);
      scan_tick = 1;
      note(64'h001F_FFFF_FFFF_FFFF, {15'h0, |(vdi_plc_en & lst_en[15:8]), vdi_plc_en & vdi_plc_val
         | ~vdi_plc_en & res[15:8], o ^ do_polarity, o, di_pin ^ di_polarity, res});
      @(negedge clk);
      scan_tick = 0;
   endtask
   task automatic flag(int n, logic f);
      repeat (n) @(negedge clk);
      note(64'h0002_0000_0000_0000, {14'h0, f, 49'h0});
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #60000;
      failures++;
      print_verdict();
   end
   initial
   begin
      repeat (5) @(negedge clk);
      note(64'hFFFF_FFFF_FFFF_FFFF, 64'h0);
      @(negedge clk);
      rst_n = 1;
      repeat (12) rand_scan();
      $display("random lists done");
      ai_thr[31:0] = 32'h0032_0064;
      ai_dly[31:0] = 32'h0000_0002;
      ai_cfg[3:0] = 4'h6;
      repeat (5)
      begin
         ai_meas[15:0] = 16'h00C8;
         repeat (3) @(negedge clk);
         ai_meas[15:0] = 16'h004B;
         repeat (2) @(negedge clk);
      end
      flag(0, 0);
      ai_meas[15:0] = 16'h00C8;
      flag(4, 0);
      flag(6, 1);
      ai_meas[15:0] = 16'h0032;
      flag(12, 1);
      lst_en = 16'h0101;
      lst_or = 16'h0100;
      lst_cnt[4:0] = 5'h01;
      lst_cnt[44:40] = 5'h01;
      lst_sel[5:0] = 6'h08;
      lst_sel[1445:1440] = 6'h38;
      lst_inv[0] = 1'b0;
      lst_inv[240] = 1'b0;
      output_func_combiner[0] = 1'b1;
      vdi_plc_en = 8'h00;
      scan_tick = 1;
      @(negedge clk);
      note(64'h0000_0100_0100_0101, 64'h0000_0100_0100_0101);
      @(negedge clk);
      scan_tick = 0;
      ai_meas[15:0] = 16'h0028;
      flag(0, 1);
      flag(1, 0);
      $display("comparators done");
      repeat (2) @(negedge clk);
      print_verdict();
   end
endmodule // tal_logic_tb_top
`default_nettype wire
